// ===== include/pss_map.svh
// Register offsets, limits, codes and timing counts for the sweep sequencer.
// Assumes a 100 MHz core clock and a 32-bit Avalon-MM register port.
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_A_CTRL   8'h00
`define PSS_A_DUR    8'h04
`define PSS_A_ENBL   8'h08
`define PSS_A_CMD    8'h0c
`define PSS_A_STAT   8'h10
`define PSS_A_VAL    8'h14
`define PSS_A_EP0    8'h20
`define PSS_A_EP9    8'h44
`define PSS_CMD_RUN  0
`define PSS_CMD_PAU  1
`define PSS_CMD_RST  2
`define PSS_CTRL_W   13
`define PSS_DUR_MAX  32'h001a_5e00
`define PSS_MS_PER_S 32'h0000_03e8
`define PSS_MS_NS    1000000
`define PSS_CLK_NS   10
`define PSS_DIV_BITS 6'h20
`define PSS_TGT_MAX  3'h4
`define PSS_TGT_AMP  3'h1
`define PSS_TGT_DC   3'h2
`define PSS_END_MAX  2'h2
`define PSS_END_ONCE 2'h0
`define PSS_END_REP  2'h1
`define PSS_DW_MAX   5'h10
`define PSS_FREQ_MIN 32'h0000_0001
`define PSS_FREQ_MAX 32'hee6b_2800
`define PSS_AMP_MIN  32'h0000_0001
`define PSS_AMP_MAX  32'h7735_9400
`define PSS_DC_LIM   32'h0000_c350
`define PSS_AUX_LIM  32'h0000_2904
`define PSS_SC_OFF   3'h0
`define PSS_SC_RST   3'h1
`define PSS_SC_RUN   3'h2
`define PSS_SC_PAU   3'h3
`define PSS_SC_DONE  3'h4
`define PSS_DW0  22'h00_0008
`define PSS_DW1  22'h00_0010
`define PSS_DW2  22'h00_001f
`define PSS_DW3  22'h00_004e
`define PSS_DW4  22'h00_009b
`define PSS_DW5  22'h00_01d5
`define PSS_DW6  22'h00_03aa
`define PSS_DW7  22'h00_0753
`define PSS_DW8  22'h00_1250
`define PSS_DW9  22'h00_249f
`define PSS_DW10 22'h00_6dd8
`define PSS_DW11 22'h00_dbba
`define PSS_DW12 22'h01_b774
`define PSS_DW13 22'h05_2468
`define PSS_DW14 22'h0a_4cb8
`define PSS_DW15 22'h14_9970
`define PSS_DW16 22'h29_32e0
`endif

// ===== include/pss_pkg.sv
// Types shared by the sweep sequencer files.
// Assumes pss_map.svh supplies the numeric constants.
package pss_pkg;
   typedef enum logic [5:0] {
      st_off   = 6'h01,
      st_rst   = 6'h02,
      st_calc  = 6'h04,
      st_run   = 6'h08,
      st_pause = 6'h10,
      st_done  = 6'h20
   } pss_state_t;

   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } pss_bus_req_t;

   typedef struct packed {
      logic [4:0] dwell;
      logic       lvl_hold;
      logic       amp_hold;
      logic [1:0] endm;
      logic       log_sp;
      logic [2:0] tgt;
   } pss_ctrl_t;
endpackage : pss_pkg

// ===== rtl/pss_divider.sv
// Sequential unsigned 32/32 restoring divider, one quotient bit per cycle.
// Assumes the caller never starts it with a zero divisor.
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_divider (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        start,
   input  wire logic [31:0] num,
   input  wire logic [31:0] den,
   output logic             done,
   output logic [31:0]      quo,
   output logic [31:0]      rem
);
   logic [5:0]  cnt_r;
   logic [31:0] d_r;
   wire  [32:0] trial = {rem, quo[31]} - {1'b0, d_r};

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_r <= 6'h00;
         d_r   <= 32'h0;
         quo   <= 32'h0;
         rem   <= 32'h0;
         done  <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            quo   <= num;
            rem   <= 32'h0;
            d_r   <= den;
            cnt_r <= `PSS_DIV_BITS;
         end else if (cnt_r != 6'h00) begin
            quo   <= {quo[30:0], ~trial[32]};
            rem   <= trial[32] ? {rem[30:0], quo[31]} : trial[31:0];
            cnt_r <= cnt_r - 6'h01;
            done  <= (cnt_r == 6'h01);
         end
      end
   end

   div_len_a: assert property (@(posedge core_clk) disable iff (reset)
      (ce && start) |=> !done) else $error("divider done right after start");
endmodule : pss_divider

// ===== rtl/pss_sequencer.sv
// Parameter sweep sequencer: registers, run control and stepping engine.
// Assumes an Avalon-MM master with waitrequest and a 100 MHz core clock.
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_sequencer #(
   parameter int unsigned MS_CYCLES = `PSS_MS_NS / `PSS_CLK_NS
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic                 ce,
   input  wire pss_pkg::pss_bus_req_t avs_req,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   output logic [31:0]               sweep_value,
   output logic [2:0]                sweep_target,
   output logic                      value_update,
   output logic                      amp_atten_fixed,
   output logic                      lvl_atten_fixed
);
   import pss_pkg::*;

   function automatic logic [31:0] clamp_ep(input logic [3:0] idx, input logic [31:0] v);
      logic signed [31:0] s;
      s = v;
      if (idx[3:1] == 3'h0)
         clamp_ep = (v < `PSS_FREQ_MIN) ? `PSS_FREQ_MIN : (v > `PSS_FREQ_MAX) ? `PSS_FREQ_MAX : v;
      else if (idx[3:1] == 3'h1)
         clamp_ep = (v < `PSS_AMP_MIN) ? `PSS_AMP_MIN
                  : (v > `PSS_AMP_MAX) ? `PSS_AMP_MAX : v;
      else if (idx[3:1] == 3'h2)
         clamp_ep = (s > $signed(`PSS_DC_LIM)) ? `PSS_DC_LIM
                  : (s < -$signed(`PSS_DC_LIM)) ? -`PSS_DC_LIM : v;
      else
         clamp_ep = (s > $signed(`PSS_AUX_LIM)) ? `PSS_AUX_LIM
                  : (s < -$signed(`PSS_AUX_LIM)) ? -`PSS_AUX_LIM : v;
   endfunction : clamp_ep

   // Frequency and amplitude are unsigned, level and aux are two's complement
   function automatic logic signed [33:0] ext(input logic [2:0] t, input logic [31:0] v);
      ext = (t <= `PSS_TGT_AMP) ? {2'b00, v} : {{2{v[31]}}, v};
   endfunction : ext

   // Piecewise-linear log2, 16 fraction bits; cheap, within about 9 percent
   function automatic logic [33:0] log2f(input logic [31:0] m);
      logic [4:0]  p;
      logic [31:0] sh;
      p = 5'h00;
      for (int i = 0; i < 32; i++)
         if (m[i]) p = i[4:0];
      sh = m << (5'h1f - p);
      log2f = {13'h0, p, sh[30:15]};
   endfunction : log2f

   function automatic logic [31:0] exp2f(input logic [33:0] d);
      logic [47:0] x;
      x = {31'h0, 1'b1, d[15:0]} << d[20:16];
      exp2f = x[47:16];
   endfunction : exp2f

   function automatic logic [21:0] dwell_ms(input logic [4:0] c);
      case (c)
         5'h00: dwell_ms = `PSS_DW0;   5'h01: dwell_ms = `PSS_DW1;
         5'h02: dwell_ms = `PSS_DW2;   5'h03: dwell_ms = `PSS_DW3;
         5'h04: dwell_ms = `PSS_DW4;   5'h05: dwell_ms = `PSS_DW5;
         5'h06: dwell_ms = `PSS_DW6;   5'h07: dwell_ms = `PSS_DW7;
         5'h08: dwell_ms = `PSS_DW8;   5'h09: dwell_ms = `PSS_DW9;
         5'h0a: dwell_ms = `PSS_DW10;  5'h0b: dwell_ms = `PSS_DW11;
         5'h0c: dwell_ms = `PSS_DW12;  5'h0d: dwell_ms = `PSS_DW13;
         5'h0e: dwell_ms = `PSS_DW14;  5'h0f: dwell_ms = `PSS_DW15;
         default: dwell_ms = `PSS_DW16;
      endcase
   endfunction : dwell_ms

   function automatic logic [2:0] code_of(input pss_state_t s);
      case (s)
         st_rst:             code_of = `PSS_SC_RST;
         st_calc, st_run:    code_of = `PSS_SC_RUN;
         st_pause:           code_of = `PSS_SC_PAU;
         st_done:            code_of = `PSS_SC_DONE;
         default:            code_of = `PSS_SC_OFF;
      endcase
   endfunction : code_of

   ////////////////////////////////////////////////////////////////////////////
   pss_ctrl_t          ctrl_r;
   pss_state_t         state_r;
   logic [31:0]        dur_r, ep_r [0:9];
   logic               enbl_r, ack_r, calc_ph_r, div_go_r, logm_r, neg_r;
   logic               down_r, dir_r, wrap_r;
   logic signed [33:0] dbg_r, dnd_r, cur_r;
   logic [31:0]        n_r, q_r, rem_r, err_r, k_r, rd_w;
   logic [31:0]        ms_cnt_r;
   logic [21:0]        dw_cnt_r;
   logic               div_done;
   logic [31:0]        div_quo, div_rem;

   wire        req      = avs_req.read | avs_req.write;
   wire        wr_go    = ack_r & avs_req.write;
   wire [7:0]  addr     = avs_req.address;
   wire [31:0] wd       = avs_req.writedata;
   wire        in_ep    = (addr >= `PSS_A_EP0) && (addr <= `PSS_A_EP9) && (addr[1:0] == 2'h0);
   wire [7:0]  ep_off   = addr - `PSS_A_EP0;
   wire [3:0]  ep_idx   = ep_off[5:2];
   wire        en_wr    = wr_go && (addr == `PSS_A_ENBL);
   wire        cmd_wr   = wr_go && (addr == `PSS_A_CMD) && (state_r != st_off);
   wire        run_c    = cmd_wr & wd[`PSS_CMD_RUN];
   wire        pau_c    = cmd_wr & wd[`PSS_CMD_PAU];
   wire        rst_c    = cmd_wr & wd[`PSS_CMD_RST];
   wire [3:0]  ib       = {ctrl_r.tgt, 1'b0};
   wire [3:0]  ie       = {ctrl_r.tgt, 1'b1};
   wire [31:0] beg_raw  = ep_r[ib];
   wire [31:0] end_raw  = ep_r[ie];
   wire signed [33:0] beg_x = ext(ctrl_r.tgt, beg_raw);
   wire signed [33:0] end_x = ext(ctrl_r.tgt, end_raw);
   // Log spacing needs both endpoints nonzero and of one sign, else linear
   wire        log_ok   = ctrl_r.log_sp && (beg_x != 0) && (end_x != 0)
                          && (beg_x[33] == end_x[33]);
   wire [31:0] beg_m    = beg_x[33] ? -beg_raw : beg_raw;
   wire [31:0] end_m    = beg_x[33] ? -end_raw : end_raw;
   wire signed [33:0] span = down_r ? dbg_r - dnd_r : dnd_r - dbg_r;
   wire [21:0] dw_ms    = dwell_ms(ctrl_r.dwell);
   wire [31:0] dur_ms   = 32'(dur_r * `PSS_MS_PER_S);
   wire [31:0] div_num  = calc_ph_r ? span[31:0] : dur_ms;
   wire [31:0] div_den  = calc_ph_r ? n_r : {10'h0, dw_ms};
   wire        tick     = (ms_cnt_r == 32'(MS_CYCLES - 1));
   wire        dw_end   = tick && (dw_cnt_r == dw_ms - 22'h1);
   wire [32:0] err_sum  = {1'b0, err_r} + {1'b0, rem_r};
   wire        carry    = err_sum >= {1'b0, n_r};
   wire [33:0] delta    = {2'b00, q_r} + {33'h0, carry};
   wire        go_down  = down_r ^ dir_r;
   wire signed [33:0] cur_nx = go_down ? cur_r - delta : cur_r + delta;
   wire [31:0] mag      = exp2f(cur_nx);
   wire [31:0] step_val = logm_r ? (neg_r ? -mag : mag) : cur_nx[31:0];
   wire        last     = (k_r + 32'h1 == n_r);

   ////////////////////////////////////////////////////////////////////////////
   // Register port: one wait cycle, write lands on the completing edge
   always_comb begin
      if (addr == `PSS_A_CTRL)      rd_w = {19'h0, ctrl_r};
      else if (addr == `PSS_A_DUR)  rd_w = dur_r;
      else if (addr == `PSS_A_ENBL) rd_w = {31'h0, enbl_r};
      else if (addr == `PSS_A_STAT) rd_w = {29'h0, code_of(state_r)};
      else if (addr == `PSS_A_VAL)  rd_w = sweep_value;
      else if (in_ep)               rd_w = ep_r[ep_idx];
      else                          rd_w = 32'h0;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ack_r           <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else if (ce) begin
         ack_r           <= req & ~ack_r;
         avs_waitrequest <= ~(req & ~ack_r);
         avs_readdata    <= rd_w;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_r <= '0;
         dur_r  <= 32'h0;
         enbl_r <= 1'b0;
      end else if (ce && wr_go) begin
         if (addr == `PSS_A_CTRL)
            ctrl_r <= '{dwell: (wd[12:8] > `PSS_DW_MAX) ? `PSS_DW_MAX : wd[12:8],
                        lvl_hold: wd[7], amp_hold: wd[6],
                        endm: (wd[5:4] > `PSS_END_MAX) ? `PSS_END_MAX : wd[5:4],
                        log_sp: wd[3],
                        tgt: (wd[2:0] > `PSS_TGT_MAX) ? `PSS_TGT_MAX : wd[2:0]};
         else if (addr == `PSS_A_DUR)
            dur_r <= (wd > `PSS_DUR_MAX) ? `PSS_DUR_MAX : wd;
         else if (addr == `PSS_A_ENBL)
            enbl_r <= wd[0];
      end
   end

   generate
      for (genvar g = 0; g < 10; g++) begin : g_ep
         always_ff @(posedge core_clk or posedge reset) begin
            if (reset)
               ep_r[g] <= clamp_ep(4'(g), 32'h0);
            else if (ce && wr_go && in_ep && (ep_idx == 4'(g)))
               ep_r[g] <= clamp_ep(4'(g), wd);
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   pss_divider u_div (
      .core_clk (core_clk),
      .reset    (reset),
      .ce       (ce),
      .start    (div_go_r),
      .num      (div_num),
      .den      (div_den),
      .done     (div_done),
      .quo      (div_quo),
      .rem      (div_rem)
   );

   // Dwell restarts on resume; a pause discards the partial interval
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ms_cnt_r <= 32'h0;
         dw_cnt_r <= 22'h0;
      end else if (ce) begin
         ms_cnt_r <= (state_r != st_run || tick) ? 32'h0 : ms_cnt_r + 32'h1;
         dw_cnt_r <= (state_r != st_run || dw_end) ? 22'h0
                   : tick ? dw_cnt_r + 22'h1 : dw_cnt_r;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r <= st_off;  sweep_value <= 32'h0;  value_update <= 1'b0;
         calc_ph_r <= 1'b0;  div_go_r <= 1'b0;  logm_r <= 1'b0;  neg_r <= 1'b0;
         down_r <= 1'b0;  dir_r <= 1'b0;  wrap_r <= 1'b0;
         dbg_r <= '0;  dnd_r <= '0;  cur_r <= '0;
         n_r <= 32'h1;  q_r <= 32'h0;  rem_r <= 32'h0;  err_r <= 32'h0;  k_r <= 32'h0;
      end else if (ce) begin
         div_go_r     <= 1'b0;
         value_update <= 1'b0;
         if (en_wr) begin
            state_r <= wd[0] ? st_rst : st_off;
            if (wd[0]) begin
               sweep_value  <= beg_raw;
               value_update <= 1'b1;
            end
         end else if (rst_c) begin
            state_r      <= st_rst;
            sweep_value  <= beg_raw;
            value_update <= 1'b1;
         end else begin
            case (state_r)
               st_rst, st_done: if (run_c) begin
                  state_r   <= st_calc;
                  calc_ph_r <= 1'b0;
                  div_go_r  <= 1'b1;
                  logm_r    <= log_ok;
                  neg_r     <= beg_x[33];
                  dbg_r     <= log_ok ? $signed(log2f(beg_m)) : beg_x;
                  dnd_r     <= log_ok ? $signed(log2f(end_m)) : end_x;
                  down_r    <= log_ok ? ((log2f(end_m) < log2f(beg_m)) ^ beg_x[33])
                                      : (end_x < beg_x);
                  sweep_value  <= beg_raw;
                  value_update <= 1'b1;
               end
               // A done left over from an aborted calc lands with the new start
               st_calc: if (div_done && !div_go_r) begin
                  if (!calc_ph_r) begin
                     n_r       <= (div_quo == 32'h0) ? 32'h1 : div_quo;
                     calc_ph_r <= 1'b1;
                     div_go_r  <= 1'b1;
                  end else begin
                     q_r <= div_quo;  rem_r <= div_rem;  err_r <= 32'h0;
                     k_r <= 32'h0;  cur_r <= dbg_r;  dir_r <= 1'b0;  wrap_r <= 1'b0;
                     state_r <= st_run;
                  end
               end
               st_pause: if (run_c) state_r <= st_run;
               st_run: if (pau_c) state_r <= st_pause;
               else if (dw_end) begin
                  value_update <= 1'b1;
                  if (wrap_r) begin
                     wrap_r <= 1'b0;  cur_r <= dbg_r;  k_r <= 32'h0;  err_r <= 32'h0;
                     sweep_value <= beg_raw;
                  end else if (last) begin
                     sweep_value <= dir_r ? beg_raw : end_raw;
                     cur_r <= dir_r ? dbg_r : dnd_r;
                     k_r <= 32'h0;  err_r <= 32'h0;
                     if (ctrl_r.endm == `PSS_END_ONCE) state_r <= st_done;
                     else if (ctrl_r.endm == `PSS_END_REP) wrap_r <= 1'b1;
                     else dir_r <= ~dir_r;
                  end else begin
                     cur_r <= cur_nx;
                     k_r   <= k_r + 32'h1;
                     err_r <= carry ? 32'(err_sum - {1'b0, n_r}) : err_sum[31:0];
                     sweep_value <= step_val;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sweep_target    <= 3'h0;
         amp_atten_fixed <= 1'b0;
         lvl_atten_fixed <= 1'b0;
      end else if (ce) begin
         sweep_target    <= ctrl_r.tgt;
         amp_atten_fixed <= ctrl_r.amp_hold && ctrl_r.tgt == `PSS_TGT_AMP
                            && state_r != st_off;
         lvl_atten_fixed <= ctrl_r.lvl_hold && ctrl_r.tgt == `PSS_TGT_DC
                            && state_r != st_off;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_req_new;  ce && req && avs_waitrequest && !ack_r;  endsequence
   sequence s_answer;   ##1 (ack_r && !avs_waitrequest);  endsequence
   bus_answer_a: assert property (s_req_new |-> s_answer)
      else $error("register access not answered in one cycle");
   run_ignored_a: assert property (
      ce && state_r == st_run && run_c && !pau_c && !rst_c && !(dw_end && last)
      |=> state_r == st_run) else $error("run disturbed a running sweep");
   pause_hold_a: assert property (
      ce && state_r == st_pause && !cmd_wr && !en_wr |=> $stable(sweep_value))
      else $error("paused value moved");
   reset_cmd_a: assert property (
      ce && rst_c && !en_wr |=> state_r == st_rst && sweep_value == $past(beg_raw))
      else $error("reset did not load begin value");
   enable_load_a: assert property (
      ce && en_wr && wd[0] |=> state_r == st_rst && sweep_value == $past(beg_raw))
      else $error("enable did not load begin value");
   dur_clamp_a: assert property (dur_r <= `PSS_DUR_MAX)
      else $error("duration above limit");
   dwell_gate_a: assert property (
      ce && state_r == st_run && !dw_end && !cmd_wr && !en_wr |=> $stable(sweep_value))
      else $error("value moved before dwell end");
   once_done_a: assert property (
      ce && state_r == st_run && dw_end && last && !wrap_r && !dir_r && !cmd_wr && !en_wr
      && ctrl_r.endm == `PSS_END_ONCE |=> state_r == st_done && sweep_value == $past(end_raw))
      else $error("once sweep did not finish on end value");
   amp_fixed_a: assert property (
      ce && ctrl_r.amp_hold && ctrl_r.tgt == `PSS_TGT_AMP && state_r != st_off
      |=> amp_atten_fixed) else $error("amplitude attenuators not held");
   state_code_a: assert property (
      !avs_waitrequest && $past(ce && addr == `PSS_A_STAT && state_r == st_pause)
      |-> avs_readdata == {29'h0, `PSS_SC_PAU}) else $error("paused state misreported");
endmodule : pss_sequencer

// ===== testbench/pss_testbench.sv
// Self-checking bench for the sweep sequencer, driven over its register port.
// Assumes pss_map.svh and pss_pkg; a short ms count keeps dwell times brief.
`timescale 1ns/1ps
`include "pss_map.svh"
module testbench;
   import pss_pkg::*;
   localparam int unsigned MS = 10;
   logic         core_clk  = 1'b0;
   logic         reset     = 1'b1;
   pss_bus_req_t req       = '0;
   logic [31:0]  rdata;
   logic [31:0]  q;
   logic [31:0]  value;
   logic [2:0]   tgt;
   logic         wreq;
   logic         upd;
   logic         amp_fx;
   logic         lvl_fx;
   int           error_cnt = 0;
   int           tests_run = 0;
   int           n;
   pss_sequencer #(.MS_CYCLES(MS)) dut (
      .core_clk(core_clk), .reset(reset), .ce(1'b1), .avs_req(req),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .sweep_value(value),
      .sweep_target(tgt), .value_update(upd), .amp_atten_fixed(amp_fx),
      .lvl_atten_fixed(lvl_fx));
   initial forever #5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Request held until waitrequest is sampled low; one idle edge after release
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      req.address <= a;
      req.read <= ~w;
      req.write <= w;
      req.writedata <= d;
      @(posedge core_clk);
      while (wreq !== 1'b0) begin
         k++;
         if (k > 50) begin
            error_cnt++;
            end_sim();
         end
         @(posedge core_clk);
      end
      q = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0000_0000);
      chk(nm, q, exp);
   endtask : rd_chk
   task automatic wait_upd(output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
      end while (upd !== 1'b1 && c < 2000);
      if (c >= 2000) begin
         error_cnt++;
         end_sim();
      end
   endtask : wait_upd
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rd_chk("state", `PSS_A_STAT, 32'h0);
      rd_chk("freq begin", 8'h20, 32'h1);
      rd_chk("unmapped", 8'h80, 32'h0);
      // Out-of-range codes come back clamped
      bus(`PSS_A_CTRL, 1'b1, 32'h0000_1f37);
      rd_chk("ctrl", `PSS_A_CTRL, 32'h0000_1024);
      bus(`PSS_A_DUR, 1'b1, 32'hffff_ffff);
      rd_chk("duration", `PSS_A_DUR, `PSS_DUR_MAX);
      bus(8'h24, 1'b1, 32'hffff_ffff);
      rd_chk("freq end", 8'h24, `PSS_FREQ_MAX);
      bus(8'h2c, 1'b1, 32'hffff_ffff);
      rd_chk("amp end", 8'h2c, `PSS_AMP_MAX);
      bus(8'h30, 1'b1, 32'hffff_0000);
      rd_chk("level begin", 8'h30, 32'hffff_3cb0);
      bus(8'h3c, 1'b1, 32'h0000_4e20);
      rd_chk("aux end", 8'h3c, `PSS_AUX_LIM);
      bus(`PSS_A_CTRL, 1'b1, 32'h0000_0041);
      bus(`PSS_A_ENBL, 1'b1, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("amp hold", {31'h0, amp_fx}, 32'h1);
      bus(`PSS_A_CTRL, 1'b1, 32'h0000_0082);
      repeat (2) @(posedge core_clk);
      chk("level hold", {31'h0, lvl_fx}, 32'h1);
      chk("target", {29'h0, tgt}, 32'h2);
      // Once, linear, aux one 0 to 125 over 1 s: 125 steps of one
      bus(`PSS_A_CTRL, 1'b1, 32'h0000_0003);
      bus(`PSS_A_DUR, 1'b1, 32'h1);
      bus(8'h38, 1'b1, 32'h0);
      bus(8'h3c, 1'b1, 32'd125);
      bus(`PSS_A_ENBL, 1'b1, 32'h0);
      rd_chk("state", `PSS_A_STAT, 32'h0);
      bus(`PSS_A_ENBL, 1'b1, 32'h1);
      rd_chk("state", `PSS_A_STAT, 32'h1);
      rd_chk("value", `PSS_A_VAL, 32'h0);
      bus(`PSS_A_CMD, 1'b1, 32'h1);
      rd_chk("state", `PSS_A_STAT, 32'h2);
      wait_upd(n);
      wait_upd(n);
      chk("dwell", {31'h0, n >= 76 && n <= 84}, 32'h1);
      rd_chk("value", `PSS_A_VAL, 32'h2);
      bus(`PSS_A_CMD, 1'b1, 32'h2);
      rd_chk("state", `PSS_A_STAT, 32'h3);
      rd_chk("paused value", `PSS_A_VAL, 32'h2);
      repeat (200) @(posedge core_clk);
      rd_chk("frozen", `PSS_A_VAL, 32'h2);
      bus(`PSS_A_CMD, 1'b1, 32'h2);
      rd_chk("state", `PSS_A_STAT, 32'h3);
      bus(`PSS_A_CMD, 1'b1, 32'h1);
      bus(`PSS_A_CMD, 1'b1, 32'h1);
      rd_chk("state", `PSS_A_STAT, 32'h2);
      bus(`PSS_A_CMD, 1'b1, 32'h4);
      rd_chk("state", `PSS_A_STAT, 32'h1);
      rd_chk("value", `PSS_A_VAL, 32'h0);
      bus(`PSS_A_CMD, 1'b1, 32'h1);
      // Poll slowly; a missed finish shows up in the checks below
      for (n = 0; n < 400 && q !== 32'h4; n++) begin
         repeat (40) @(posedge core_clk);
         bus(`PSS_A_STAT, 1'b0, 32'h0);
      end
      rd_chk("state", `PSS_A_STAT, 32'h4);
      rd_chk("value", `PSS_A_VAL, 32'd125);
      // Log spacing, repeat: 100 to 6400 mHz in six doublings of 155 ms
      bus(8'h20, 1'b1, 32'h0000_0064);
      bus(8'h24, 1'b1, 32'h0000_1900);
      bus(`PSS_A_CTRL, 1'b1, 32'h0000_0418);
      bus(`PSS_A_ENBL, 1'b1, 32'h1);
      bus(`PSS_A_CMD, 1'b1, 32'h1);
      wait_upd(n);
      rd_chk("log step", `PSS_A_VAL, 32'h0000_00c8);
      repeat (5) wait_upd(n);
      rd_chk("log end", `PSS_A_VAL, 32'h0000_1900);
      rd_chk("state", `PSS_A_STAT, 32'h2);
      wait_upd(n);
      rd_chk("restart", `PSS_A_VAL, 32'h0000_0064);
      // Up and down, aux one 0 to 60: six steps of ten, then back down
      bus(`PSS_A_CTRL, 1'b1, 32'h0000_0423);
      bus(8'h3c, 1'b1, 32'h0000_003c);
      bus(`PSS_A_ENBL, 1'b1, 32'h1);
      bus(`PSS_A_CMD, 1'b1, 32'h1);
      repeat (6) wait_upd(n);
      rd_chk("turn", `PSS_A_VAL, 32'h0000_003c);
      wait_upd(n);
      rd_chk("down", `PSS_A_VAL, 32'h0000_0032);
      end_sim();
   end
endmodule : testbench
